/* logic/mfc_machine_function_control.sv */
`timescale 1ns/1ns
`include "mfc_params.svh"
// How it works
// - Control word is 32 bits, eight four-bit digits.
// - Word bit 00 is MSB, bit 31 the LSB.
// - Digits 6 and 7 hold status driven by the processor.
// - Bits 29..24 report fault, parity, interrupts, restart, micro and macro run.
// - Digits 2..5 are mode switches, step/stop/skip/protect in bits 11..8.
// - Bit 31 sets on an arithmetic overflow.
// - Bit 30 set while a protected instruction executes.
// - Bit 13 set: breakpoint interrupts; clear: breakpoint stops.
// - Bit 12 selects micro level when set, macro level when clear.
// - Bit 18 enables multilevel indirect addressing.
// - Bit 19 comes from wiring only; writes never change it.
// - Bits 07..04 select the first display group register.
// - Bits 03..00 select the second display group register.
// - Local panel and remote console share one display and can both change it; local wins when both write.
// - Software can read every switch and indicator, and set all but bit 19 and bits 30..24.
module mfc_machine_function_control #(
  parameter logic [31:0] MODE_DEFAULT = `MFC_RESET_WORD
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Operator panels
  input wire mfc_pkg::mfc_panel_type local_panel,
  input wire mfc_pkg::mfc_panel_type remote_console,
  output logic [31:0] panel_display,
  // Processor events and levels
  input wire logic alu_overflow,
  input wire logic prot_instr_exec,
  input wire logic [5:0] status_levels,
  input wire logic ucode_we_strap,
  input wire logic breakpoint_hit,
  // Decoded controls
  output mfc_pkg::mfc_mode_type mode,
  output logic breakpoint_irq,
  output logic breakpoint_stop,
  output logic irq
);
  // ----------------------------------------
  // Word storage
  // ----------------------------------------
  logic [31:0] word;
  logic [31:0] next_word;
  logic [31:0] wr_data;
  logic wr_any;
  logic [`MFC_IRQ_BITS-1:0] irq_status;
  logic [`MFC_IRQ_BITS-1:0] irq_enable;
  logic [`MFC_IRQ_BITS-1:0] irq_event;
  logic sw_write;
  localparam logic [31:0] KEEP_MASK = `MFC_UNDEF_MASK | `MFC_WIRED_MASK;

  assign sw_write = reg_write && reg_addr == `MFC_OFF_CONTROL;
  // Software first, then local, then remote; identical effect from each
  always_comb begin
    wr_any = sw_write || local_panel.wr || remote_console.wr;
    if (sw_write) begin
      wr_data = reg_wdata;
    end else if (local_panel.wr) begin
      wr_data = local_panel.data;
    end else begin
      wr_data = remote_console.data;
    end
  end

  always_comb begin
    next_word = word;
    if (wr_any) begin
      next_word = (wr_data & ~KEEP_MASK) | (word & KEEP_MASK);
    end
    // Status digits track processor; overflow sticks until written clear
    next_word[`MFC_VEC(`MFC_B_OVERFLOW)] = next_word[`MFC_VEC(`MFC_B_OVERFLOW)]
      | alu_overflow;
    next_word[`MFC_VEC(`MFC_B_PROT_INSTR)] = prot_instr_exec;
    next_word[`MFC_VEC(`MFC_B_MACRO_RUN):`MFC_VEC(`MFC_B_PROT_FAULT)] =
      status_levels;
    next_word[`MFC_VEC(`MFC_B_UCODE_WE)] = ucode_we_strap;
    next_word = next_word & ~`MFC_UNDEF_MASK;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      word <= (MODE_DEFAULT & ~`MFC_STATUS_MASK & ~KEEP_MASK);
    end else begin
      word <= next_word;
    end
  end

  // ----------------------------------------
  // Decoded fields
  // ----------------------------------------
  always_comb begin
    mode.brk_irq = word[`MFC_VEC(`MFC_B_BRK_IRQ)];
    mode.brk_micro = word[`MFC_VEC(`MFC_B_BRK_MICRO)];
    mode.step = word[`MFC_VEC(`MFC_B_STEP)];
    mode.sel_stop = word[`MFC_VEC(`MFC_B_SEL_STOP)];
    mode.sel_skip = word[`MFC_VEC(`MFC_B_SEL_SKIP)];
    mode.prot_sw = word[`MFC_VEC(`MFC_B_PROT_SW)];
    mode.multi_ind = word[`MFC_VEC(`MFC_B_MULTI_IND)];
    mode.display1 = word[`MFC_VEC(4):`MFC_VEC(7)];
    mode.display0 = word[`MFC_VEC(0):`MFC_VEC(3)];
  end

  assign breakpoint_irq = breakpoint_hit && mode.brk_irq;
  assign breakpoint_stop = breakpoint_hit && !mode.brk_irq;

  always_ff @(posedge clock) begin
    if (rst) begin
      panel_display <= 32'h0000_0000;
    end else begin
      panel_display <= next_word;
    end
  end

  // ----------------------------------------
  // Interrupts: overflow, breakpoint, protect fault
  // ----------------------------------------
  assign irq_event = {status_levels[0], breakpoint_irq, alu_overflow};
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_status <= '0;
    end else if (reg_write && reg_addr == `MFC_OFF_IRQ_CLEAR) begin
      irq_status <= (irq_status & ~reg_wdata[`MFC_IRQ_BITS-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_enable <= '0;
    end else if (reg_write && reg_addr == `MFC_OFF_IRQ_ENABLE) begin
      irq_enable <= reg_wdata[`MFC_IRQ_BITS-1:0];
    end
  end
  assign irq = |(irq_status & irq_enable);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        `MFC_OFF_CONTROL: reg_rdata <= word;
        `MFC_OFF_IRQ_STATUS: reg_rdata <= {29'h0000_0000, irq_status};
        `MFC_OFF_IRQ_ENABLE: reg_rdata <= {29'h0000_0000, irq_enable};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_wired_bit_kept: assert property (@(posedge clock) disable iff (rst)
    ##1 word[`MFC_VEC(`MFC_B_UCODE_WE)] == $past(ucode_we_strap))
    else $error("wired bit differs from strap");
  a_undef_zero: assert property (@(posedge clock) disable iff (rst)
    (word & `MFC_UNDEF_MASK) == 32'h0000_0000)
    else $error("undefined bits nonzero");
  a_overflow_sets: assert property (@(posedge clock) disable iff (rst)
    alu_overflow |=> word[0])
    else $error("overflow not recorded");
  a_prot_instr: assert property (@(posedge clock) disable iff (rst)
    ##1 word[1] == $past(prot_instr_exec))
    else $error("protected instruction bit wrong");
  a_status_track: assert property (@(posedge clock) disable iff (rst)
    ##1 word[7:2] == $past(status_levels))
    else $error("status digit mismatch");
  a_brk_route: assert property (@(posedge clock) disable iff (rst)
    breakpoint_hit |-> (breakpoint_irq != breakpoint_stop))
    else $error("breakpoint routed wrong");
  a_remote_write: assert property (@(posedge clock) disable iff (rst)
    (remote_console.wr && !local_panel.wr && !sw_write) |=>
      mode.display0 == $past(remote_console.data[31:28]))
    else $error("remote write lost");
  a_sw_readback: assert property (@(posedge clock) disable iff (rst)
    (sw_write ##1 (reg_read && reg_addr == `MFC_OFF_CONTROL && !wr_any)) |=>
      reg_rdata[31:16] == $past(reg_wdata, 2) >> 16)
    else $error("mode readback wrong");

  // ----------------------------------------
  // Multi-step sequences
  // ----------------------------------------
  // Kept tiny so each property reads as a story
  sequence s_sw_word_write;
    reg_write && reg_addr == `MFC_OFF_CONTROL;
  endsequence
  sequence s_word_read;
    reg_read && reg_addr == `MFC_OFF_CONTROL && !wr_any;
  endsequence
  sequence s_local_only;
    local_panel.wr && !sw_write;
  endsequence
  sequence s_local_over_remote;
    local_panel.wr && remote_console.wr && !sw_write;
  endsequence
  sequence s_irq_clear_write;
    reg_write && reg_addr == `MFC_OFF_IRQ_CLEAR;
  endsequence
  sequence s_irq_enable_write;
    reg_write && reg_addr == `MFC_OFF_IRQ_ENABLE;
  endsequence

  // ----------------------------------------
  // Writers and priority
  // ----------------------------------------
  a_local_write: assert property (
    @(posedge clock) disable iff (rst) s_local_only |=>
      mode.display0 == $past(local_panel.data[31:28]))
    else $error("local write lost");

  a_sw_write_word: assert property (
    @(posedge clock) disable iff (rst) s_sw_word_write |=>
      word[31:28] == $past(reg_wdata[31:28]))
    else $error("software write lost");

  a_sw_priority: assert property (
    @(posedge clock) disable iff (rst) sw_write && (local_panel.wr || remote_console.wr) |=>
      word[31:16] == $past(reg_wdata[31:16]))
    else $error("software write did not win");

  a_local_priority: assert property (
    @(posedge clock) disable iff (rst) s_local_over_remote |=>
      word[31:16] == $past(local_panel.data[31:16]))
    else $error("local write did not win");

  a_wired_no_write: assert property (
    @(posedge clock) disable iff (rst) sw_write && !ucode_we_strap |=>
      !word[`MFC_VEC(`MFC_B_UCODE_WE)])
    else $error("wired bit took a write");

  a_mode_hold: assert property (
    @(posedge clock) disable iff (rst) !wr_any |=>
      word[31:16] == $past(word[31:16]))
    else $error("mode bits moved without a write");

  a_readback_low: assert property (
    @(posedge clock) disable iff (rst) (s_sw_word_write ##1 s_word_read) |=>
      reg_rdata[15] == $past(reg_wdata[15], 2))
    else $error("low mode readback wrong");

  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  a_overflow_sticky: assert property (
    @(posedge clock) disable iff (rst) !wr_any && word[0] |=>
      word[0])
    else $error("overflow dropped by itself");

  a_overflow_clear: assert property (
    @(posedge clock) disable iff (rst) sw_write && !reg_wdata[0] && !alu_overflow |=>
      !word[0])
    else $error("overflow not cleared by write");

  a_prot_set: assert property (
    @(posedge clock) disable iff (rst) prot_instr_exec |=>
      word[1])
    else $error("protected instruction not shown");

  a_display_mirror: assert property (
    @(posedge clock) disable iff (rst)
      ##1 panel_display == word)
    else $error("panel display differs from word");

  a_undef_read: assert property (
    @(posedge clock) disable iff (rst) reg_read && reg_addr == `MFC_OFF_CONTROL |=>
      (reg_rdata & `MFC_UNDEF_MASK) == 32'h0000_0000)
    else $error("undefined bits read nonzero");

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  a_brk_irq_route: assert property (
    @(posedge clock) disable iff (rst) breakpoint_hit && mode.brk_irq |->
      breakpoint_irq && !breakpoint_stop)
    else $error("breakpoint should interrupt");

  a_brk_stop_route: assert property (
    @(posedge clock) disable iff (rst) breakpoint_hit && !mode.brk_irq |->
      breakpoint_stop && !breakpoint_irq)
    else $error("breakpoint should stop");

  a_brk_quiet: assert property (
    @(posedge clock) disable iff (rst) !breakpoint_hit |->
      !breakpoint_irq && !breakpoint_stop)
    else $error("breakpoint output without a hit");

  a_multi_ind: assert property (
    @(posedge clock) disable iff (rst) s_sw_word_write |=>
      mode.multi_ind == $past(reg_wdata[13]))
    else $error("indirect mode bit wrong");

  a_display1_write: assert property (
    @(posedge clock) disable iff (rst) s_sw_word_write |=>
      mode.display1 == $past(reg_wdata[27:24]))
    else $error("first display selector wrong");

  a_brk_micro_write: assert property (
    @(posedge clock) disable iff (rst) s_sw_word_write |=>
      mode.brk_micro == $past(reg_wdata[19]))
    else $error("level select bit wrong");

  a_step_write: assert property (
    @(posedge clock) disable iff (rst) s_sw_word_write |=>
      mode.step == $past(reg_wdata[20]))
    else $error("step switch wrong");

  // ----------------------------------------
  // Interrupt flags
  // ----------------------------------------
  a_irq_set_wins: assert property (
    @(posedge clock) disable iff (rst) alu_overflow |=>
      irq_status[0])
    else $error("overflow flag not set");

  a_bp_irq_status: assert property (
    @(posedge clock) disable iff (rst) breakpoint_irq |=>
      irq_status[1])
    else $error("breakpoint flag not set");

  a_pf_irq: assert property (
    @(posedge clock) disable iff (rst) status_levels[0] |=>
      irq_status[2])
    else $error("protect fault flag not set");

  a_irq_clear: assert property (
    @(posedge clock) disable iff (rst)
      (s_irq_clear_write ##0 (reg_wdata[0] && !alu_overflow)) |=> !irq_status[0])
    else $error("overflow flag not cleared");

  a_irq_enable_write: assert property (
    @(posedge clock) disable iff (rst) s_irq_enable_write |=>
      irq_enable == $past(reg_wdata[`MFC_IRQ_BITS-1:0]))
    else $error("enable write lost");

  a_irq_sticky: assert property (
    @(posedge clock) disable iff (rst) !(reg_write && reg_addr == `MFC_OFF_IRQ_CLEAR) |=>
      (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("flag dropped without a clear");

  a_irq_raise: assert property (
    @(posedge clock) disable iff (rst)
      alu_overflow && irq_enable[0] && !(reg_write && reg_addr == `MFC_OFF_IRQ_ENABLE) |=> irq)
    else $error("enabled overflow gave no interrupt");

  // ----------------------------------------
  // Read port and reset
  // ----------------------------------------
  a_rdata_hold: assert property (
    @(posedge clock) disable iff (rst) !reg_read |=>
      reg_rdata == $past(reg_rdata))
    else $error("read data moved without a read");

  a_rdata_status: assert property (
    @(posedge clock) disable iff (rst) reg_read && reg_addr == `MFC_OFF_IRQ_STATUS |=>
      reg_rdata == {29'h0000_0000, $past(irq_status)})
    else $error("flag readback wrong");

  a_rdata_clear_zero: assert property (
    @(posedge clock) disable iff (rst) reg_read && reg_addr == `MFC_OFF_IRQ_CLEAR |=>
      reg_rdata == 32'h0000_0000)
    else $error("clear register read nonzero");

  a_reset_clear: assert property (
    @(posedge clock) rst |=>
      word[7:0] == 8'h00 && irq_status == '0 && reg_rdata == 32'h0000_0000)
    else $error("reset left status set");

  a_reset_modes: assert property (
    @(posedge clock) rst |=>
      word[31:16] == MODE_DEFAULT[31:16])
    else $error("reset mode default wrong");

endmodule

/* logic/mfc_params.svh */
`ifndef MFC_PARAMS_SVH
`define MFC_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MFC_OFF_CONTROL 4'h0
`define MFC_OFF_IRQ_STATUS 4'h4
`define MFC_OFF_IRQ_CLEAR 4'h8
`define MFC_OFF_IRQ_ENABLE 4'hc
// ----------------------------------------
// Word layout, bit 00 is the word's MSB (vector bit 31)
// ----------------------------------------
`define MFC_VEC(n) (31 - (n))
`define MFC_B_OVERFLOW 31
`define MFC_B_PROT_INSTR 30
`define MFC_B_PROT_FAULT 29
`define MFC_B_PARITY 28
`define MFC_B_INT_ACTIVE 27
`define MFC_B_AUTO_RESTART 26
`define MFC_B_MICRO_RUN 25
`define MFC_B_MACRO_RUN 24
`define MFC_B_UCODE_WE 19
`define MFC_B_MULTI_IND 18
`define MFC_B_BRK_IRQ 13
`define MFC_B_BRK_MICRO 12
`define MFC_B_STEP 11
`define MFC_B_SEL_STOP 10
`define MFC_B_SEL_SKIP 9
`define MFC_B_PROT_SW 8
// Vector masks: status digits 6-7, undefined bits 23,22,17, wired bit 19
`define MFC_STATUS_MASK 32'h0000_00ff
`define MFC_UNDEF_MASK 32'h0000_4300
`define MFC_WIRED_MASK 32'h0000_1000
`define MFC_RESET_WORD 32'h0000_0000
`define MFC_IRQ_BITS 3
`endif

/* logic/mfc_pkg.sv */
package mfc_pkg;
  typedef struct packed {
    logic overflow;
    logic prot_instr;
    logic prot_fault;
    logic parity;
    logic int_active;
    logic auto_restart;
    logic micro_run;
    logic macro_run;
  } mfc_status_type;
  typedef struct packed {
    logic brk_irq;
    logic brk_micro;
    logic step;
    logic sel_stop;
    logic sel_skip;
    logic prot_sw;
    logic multi_ind;
    logic [3:0] display1;
    logic [3:0] display0;
  } mfc_mode_type;
  typedef struct packed {
    logic wr;
    logic [31:0] data;
  } mfc_panel_type;
endpackage

/* tb/mfc_panel_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Operator panel stand-in
// ----------------------------------------
module mfc_panel_model (
  // Clock
  input wire logic clock,
  // Panel side
  output mfc_pkg::mfc_panel_type panel
);
  initial panel = '{wr: 1'b0, data: 32'h0000_0000};
  // Data inverted when idle so stale words never look valid
  task automatic send(input logic [31:0] d);
    @(posedge clock);
    panel <= '{wr: 1'b1, data: d};
    @(posedge clock);
    panel <= '{wr: 1'b0, data: ~d};
  endtask
endmodule

/* tb/mfc_machine_function_control_test.sv */
`timescale 1ns/1ns
module mfc_machine_function_control_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata, panel_display, d;
  mfc_pkg::mfc_panel_type local_panel, remote_console;
  logic alu_overflow = 1'b0;
  logic prot_instr_exec = 1'b0;
  logic [5:0] status_levels = 6'h00;
  logic ucode_we_strap = 1'b0;
  logic breakpoint_hit = 1'b0;
  mfc_pkg::mfc_mode_type mode;
  logic breakpoint_irq, breakpoint_stop, irq;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  integer seed = 32'h3bab;
  mfc_machine_function_control mfc_machine_function_control_inst (.*);
  mfc_panel_model local_inst (.clock(clock), .panel(local_panel));
  mfc_panel_model remote_inst (.clock(clock), .panel(remote_console));
  initial forever #5 clock = ~clock;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] exp_word(input logic [31:0] w);
    return (w & 32'hffff_ac01) | {19'h0, ucode_we_strap, 4'h0, status_levels, prot_instr_exec, 1'b0};
  endfunction
  function automatic logic [31:0] exp_mode(input logic [31:0] e);
    return {17'h0, e[18], e[19], e[20], e[21], e[22], e[23], e[13], e[27:24], e[31:28]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(4'h0, 32'h0000_0000);
    rd(4'h2, 32'h0000_0000);
    $display("reset test done");
    for (int i = 0; i < 40; i++) begin
      d = (i == 0) ? 32'hffff_ffff : $random(seed);
      @(posedge clock);
      {prot_instr_exec, status_levels, ucode_we_strap} <= 8'($random(seed));
      case (i % 3)
        0: wr(4'h0, d);
        1: local_inst.send(d);
        default: remote_inst.send(d);
      endcase
      rd(4'h0, exp_word(d));
      chk("display", exp_word(d), panel_display);
      chk("mode", exp_mode(exp_word(d)), 32'(mode));
    end
    $display("word test done");
    @(posedge clock);
    {prot_instr_exec, status_levels, ucode_we_strap} <= 8'h00;
    wr(4'h0, 32'h0000_0000);
    wr(4'h8, 32'h0000_0007);
    wr(4'hc, 32'h0000_0001);
    chk("irq idle", 32'h0, 32'(irq));
    @(posedge clock);
    alu_overflow <= 1'b1;
    @(posedge clock);
    alu_overflow <= 1'b0;
    rd(4'h0, 32'h0000_0001);
    chk("irq set", 32'h1, 32'(irq));
    rd(4'h4, 32'h0000_0001);
    wr(4'hc, 32'h0000_0000);
    chk("irq masked", 32'h0, 32'(irq));
    wr(4'hc, 32'h0000_0001);
    wr(4'h8, 32'h0000_0001);
    chk("irq cleared", 32'h0, 32'(irq));
    rd(4'h8, 32'h0000_0000);
    $display("interrupt test done");
    @(posedge clock);
    breakpoint_hit <= 1'b1;
    wr(4'h0, 32'h0004_0000);
    chk("bp irq", 32'h1, 32'({breakpoint_stop, breakpoint_irq}));
    wr(4'h0, 32'h0000_0000);
    chk("bp stop", 32'h2, 32'({breakpoint_stop, breakpoint_irq}));
    $display("breakpoint test done");
    finish_test();
  end
endmodule
